// [rxf_pkg.sv]
// Package for the receive frame acceptance filter: offsets, fields, types
package rxf_pkg;

  // Register byte offsets (base register and its write aliases)
  localparam logic [3:0] RXF_OFS_CFG = 4'h0;
  localparam logic [3:0] RXF_OFS_CLR = 4'h4;
  localparam logic [3:0] RXF_OFS_SET = 4'h8;
  localparam logic [3:0] RXF_OFS_INV = 4'hC;
  localparam logic [3:0] RXF_OFS_STAT = 4'h0;
  localparam logic [1:0] RXF_BLK_CFG = 2'h0;
  localparam logic [1:0] RXF_BLK_STAT = 2'h1;

  // Field positions in receive_filter_config
  localparam int RXF_B_HASH_EN = 15;
  localparam int RXF_B_WAKE_EN = 14;
  localparam int RXF_B_PAT_INV = 12;
  localparam int RXF_B_MODE_HI = 11;
  localparam int RXF_B_MODE_LO = 8;
  localparam int RXF_B_BADFCS = 7;
  localparam int RXF_B_GOODFCS = 6;
  localparam int RXF_B_SHORT_COL = 5;
  localparam int RXF_B_SHORT_REJ = 4;
  localparam int RXF_B_STA_UC = 3;
  localparam int RXF_B_FOR_UC = 2;
  localparam int RXF_B_GROUP = 1;
  localparam int RXF_B_BCAST = 0;

  // Implemented bits and reset value
  localparam logic [31:0] RXF_CFG_MASK = 32'h0000DFFF;
  localparam logic [31:0] RXF_CFG_RESET = 32'h00000000;
  localparam logic [31:0] RXF_UNMAPPED = 32'h00000000;

  // Short-frame limit in bytes
  localparam logic [15:0] RXF_MIN_LEN = 16'h0040;

  // Pattern modes
  localparam logic [3:0] RXF_PM_OFF = 4'h0;
  localparam logic [3:0] RXF_PM_CSUM = 4'h1;
  localparam logic [3:0] RXF_PM_STA_A = 4'h2;
  localparam logic [3:0] RXF_PM_STA_B = 4'h3;
  localparam logic [3:0] RXF_PM_UC_A = 4'h4;
  localparam logic [3:0] RXF_PM_UC_B = 4'h5;
  localparam logic [3:0] RXF_PM_BC_A = 4'h6;
  localparam logic [3:0] RXF_PM_BC_B = 4'h7;
  localparam logic [3:0] RXF_PM_HASH = 4'h8;
  localparam logic [3:0] RXF_PM_WAKE = 4'h9;

  // Per-frame results from the MAC receive path
  typedef struct packed {
    logic stationHit;
    logic unicast;
    logic multicast;
    logic broadcast;
    logic fcsValid;
    logic hashHit;
    logic wakeHit;
    logic csumHit;
    logic [15:0] length;
  } rxf_frame_t;

  // Verdict to the receive DMA
  typedef struct packed {
    logic accept;
    logic reject;
  } rxf_verdict_t;

endpackage

// [rxf_filter.sv]
// Receive frame acceptance filter with Avalon-MM configuration slave
// Operation
// - Mode field bits 11:8; zero means pattern match always fails.
// - Mode 1: pattern true when invert bit differs from checksum hit.
// - Modes 2,3: checksum term and destination equals station address.
// - Modes 4,5: checksum term and unicast destination.
// - Modes 6,7: checksum term and broadcast destination.
// - Mode 8: checksum term and hash table hit.
// - Mode 9: checksum term and wake-up frame recognised.
// - Bit 7 set: accept only frames with invalid FCS.
// - Bit 6 set: accept only frames with valid FCS.
// - Bit 5 set: accept only runt frames.
// - Runt is under 64 bytes; needs valid FCS when bit 6 set.
// - Bit 4 set: reject every frame under 64 bytes.
// - Clear alias at +0x4 clears bits written one; reads ignored.
// - Set alias at +0x8 sets bits written one; reads ignored.
// - Invert alias at +0xC toggles bits written one; reads ignored.
// - Hash hit for mode 8 ignores the hash enable bit.
// - Wake-up match for mode 9 ignores the wake enable bit.
// - Bits 3..0 accept station unicast, foreign unicast, multicast, broadcast.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rxf_filter
  import rxf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic frameValid,
  input wire rxf_frame_t frameInfo,
  output rxf_verdict_t verdict_r,
  output logic verdictValid_r,
  output logic [31:0] cfgOut_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] readData_r;
  logic ack_r;
  logic [31:0] beMask;
  logic [31:0] wrBits;
  logic [15:0] acceptCount_r;
  logic [15:0] rejectCount_r;
  logic [15:0] acceptCount_nxt;
  logic [15:0] rejectCount_nxt;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  assign beMask = lane_mask(avsByteEnable);
  assign wrBits = avsWriteData & beMask & RXF_CFG_MASK;

  // One wait cycle per access; answer in the second cycle of the request
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_r;
  assign avsReadData = readData_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else if (clkEn) begin
      ack_r <= (avsRead | avsWrite) & ~ack_r;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (avsWrite && !ack_r && avsAddress[4] == RXF_BLK_CFG[0]) begin
      unique case (avsAddress[3:0])
        RXF_OFS_CFG: cfg_nxt = (cfg_r & ~(beMask & RXF_CFG_MASK)) | wrBits;
        RXF_OFS_CLR: cfg_nxt = cfg_r & ~wrBits;
        RXF_OFS_SET: cfg_nxt = cfg_r | wrBits;
        RXF_OFS_INV: cfg_nxt = cfg_r ^ wrBits;
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  // No interlock on receive enable; software keeps it quiet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= RXF_CFG_RESET;
      cfgOut_r <= RXF_CFG_RESET;
    end else if (clkEn) begin
      cfg_r <= cfg_nxt;
      cfgOut_r <= cfg_nxt;
    end
  end

  // Aliases read as zero; counters show the block's own activity
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readData_r <= 32'h00000000;
    end else if (clkEn) begin
      if (avsRead && !ack_r) begin
        if (avsAddress == {RXF_BLK_CFG[0], RXF_OFS_CFG}) begin
          readData_r <= cfg_r;
        end else if (avsAddress == {RXF_BLK_STAT[0], RXF_OFS_STAT}) begin
          readData_r <= {rejectCount_r, acceptCount_r};
        end else begin
          readData_r <= RXF_UNMAPPED;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame evaluation

  logic [3:0] mode;
  logic patInv;
  logic csumTerm;
  logic patHit;
  logic isShort;
  logic runtOk;
  logic passAny;
  logic qualOk;
  logic acceptNow;

  assign mode = cfg_r[RXF_B_MODE_HI:RXF_B_MODE_LO];
  assign patInv = cfg_r[RXF_B_PAT_INV];
  assign csumTerm = patInv ^ frameInfo.csumHit;
  assign isShort = frameInfo.length < RXF_MIN_LEN;
  assign runtOk = isShort & (~cfg_r[RXF_B_GOODFCS] | frameInfo.fcsValid);

  always_comb begin
    patHit = 1'b0;
    unique case (mode)
      RXF_PM_OFF: patHit = 1'b0;
      RXF_PM_CSUM: patHit = csumTerm;
      RXF_PM_STA_A, RXF_PM_STA_B: patHit = csumTerm & frameInfo.stationHit;
      RXF_PM_UC_A, RXF_PM_UC_B: patHit = csumTerm & frameInfo.unicast;
      RXF_PM_BC_A, RXF_PM_BC_B: patHit = csumTerm & frameInfo.broadcast;
      RXF_PM_HASH: patHit = csumTerm & frameInfo.hashHit;
      RXF_PM_WAKE: patHit = csumTerm & frameInfo.wakeHit;
      // Reserved mode codes never match
      default: patHit = 1'b0;
    endcase
  end

  always_comb begin
    passAny = (cfg_r[RXF_B_STA_UC] & frameInfo.unicast & frameInfo.stationHit)
      | (cfg_r[RXF_B_FOR_UC] & frameInfo.unicast & ~frameInfo.stationHit)
      | (cfg_r[RXF_B_GROUP] & frameInfo.multicast)
      | (cfg_r[RXF_B_BCAST] & frameInfo.broadcast)
      | (cfg_r[RXF_B_HASH_EN] & frameInfo.hashHit)
      | (cfg_r[RXF_B_WAKE_EN] & frameInfo.wakeHit)
      | patHit;
    qualOk = 1'b1;
    if (cfg_r[RXF_B_BADFCS] && frameInfo.fcsValid) begin
      qualOk = 1'b0;
    end
    if (cfg_r[RXF_B_GOODFCS] && !frameInfo.fcsValid) begin
      qualOk = 1'b0;
    end
    if (cfg_r[RXF_B_SHORT_COL] && !runtOk) begin
      qualOk = 1'b0;
    end
    if (cfg_r[RXF_B_SHORT_REJ] && isShort) begin
      qualOk = 1'b0;
    end
  end

  assign acceptNow = passAny & qualOk;

  // Verdict one cycle after frameValid, held until the next frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      verdict_r <= '0;
      verdictValid_r <= 1'b0;
    end else if (clkEn) begin
      verdictValid_r <= frameValid;
      if (frameValid) begin
        verdict_r.accept <= acceptNow;
        verdict_r.reject <= ~acceptNow;
      end
    end
  end

  // Counters wrap; one status read returns both counters together
  always_comb begin
    acceptCount_nxt = acceptCount_r;
    rejectCount_nxt = rejectCount_r;
    if (frameValid && acceptNow) begin
      acceptCount_nxt = acceptCount_r + 16'h0001;
    end
    if (frameValid && !acceptNow) begin
      rejectCount_nxt = rejectCount_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acceptCount_r <= 16'h0000;
      rejectCount_r <= 16'h0000;
    end else if (clkEn) begin
      acceptCount_r <= acceptCount_nxt;
      rejectCount_r <= rejectCount_nxt;
    end
  end

endmodule // rxf_filter

`default_nettype wire

// [rxf_filter_sva.sv]
// Assertion checker for the receive frame acceptance filter
`timescale 1ns/1ps
`default_nettype none
module rxf_filter_sva
  import rxf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitRequest,
  input wire logic frameValid,
  input wire rxf_frame_t frameInfo,
  input wire rxf_verdict_t verdict_r,
  input wire logic verdictValid_r,
  input wire logic [31:0] cfgOut_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_frame;
    frameValid && clkEn;
  endsequence
  sequence s_req;
    (avsRead || avsWrite) && clkEn;
  endsequence
  chk_bus_one_wait: assert property (s_req ##0 avsWaitRequest |=> !avsWaitRequest)
    else $error("more than one wait cycle");
  chk_bus_wait_first: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest)
    else $error("answer without wait cycle");
  chk_verdict_latency: assert property (s_frame |=> verdictValid_r)
    else $error("verdict not one cycle after frame");
  chk_verdict_excl: assert property (verdictValid_r |-> verdict_r.accept ^ verdict_r.reject)
    else $error("verdict not exclusive");
  chk_short_reject: assert property (
    s_frame ##0 (cfgOut_r[4] && frameInfo.length < RXF_MIN_LEN) |=> !verdict_r.accept)
    else $error("short frame accepted");
  chk_good_fcs: assert property (
    s_frame ##0 (cfgOut_r[6] && !frameInfo.fcsValid) |=> !verdict_r.accept)
    else $error("bad fcs accepted");
  chk_bad_fcs: assert property (
    s_frame ##0 (cfgOut_r[7] && frameInfo.fcsValid) |=> !verdict_r.accept)
    else $error("good fcs collected");
  chk_bcast_accept: assert property (
    s_frame ##0 (cfgOut_r[15:4] == 12'h000 && cfgOut_r[0] && frameInfo.broadcast)
    |=> verdict_r.accept)
    else $error("broadcast refused");
endmodule // rxf_filter_sva
`default_nettype wire

// [rxf_mac_model.sv]
// Behavioural MAC receive path handing per-frame results to the filter
`timescale 1ns/1ps
`default_nettype none
module rxf_mac_model
  import rxf_pkg::*;
(
  output logic frameValid,
  output rxf_frame_t frameInfo,
  input wire logic sys_clk
);
  initial begin
    frameValid = 1'b0;
    frameInfo = '0;
  end
  ////////////////////////////////////////
  // Idle info is inverted so a filter reading stale results cannot pass
  task automatic send(input rxf_frame_t info);
    @(posedge sys_clk);
    frameValid <= 1'b1;
    frameInfo <= info;
    @(posedge sys_clk);
    frameValid <= 1'b0;
    frameInfo <= ~info;
  endtask
endmodule // rxf_mac_model
`default_nettype wire

// [rxf_filter_bench.sv]
// Self-checking bench for the receive frame acceptance filter
`timescale 1ns/1ps
`default_nettype none
module rxf_filter_bench
  import rxf_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [31:0] avsReadData, cfgOut_r, c, junk;
  logic avsWaitRequest, frameValid, verdictValid_r;
  rxf_frame_t frameInfo, fi;
  rxf_verdict_t verdict_r;
  int failures = 0;
  int compares = 0;
  logic [15:0] nAcc = 16'h0000;
  logic [15:0] nRej = 16'h0000;
  always #50 sys_clk = ~sys_clk;
  rxf_mac_model mac (.sys_clk(sys_clk), .frameValid(frameValid), .frameInfo(frameInfo));
  rxf_filter dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .frameValid(frameValid), .frameInfo(frameInfo), .verdict_r(verdict_r),
    .verdictValid_r(verdictValid_r), .cfgOut_r(cfgOut_r));
  ////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp2(input string n, input rxf_verdict_t e, input rxf_verdict_t g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  // Request held until a rising edge sees waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n <= 20);
    q = avsReadData;
    if (n > 20) begin
      failures++;
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    cmp32("readData", e, q);
    if (a == 5'h00) begin
      cmp32("cfgOut", e, cfgOut_r);
    end
  endtask
  function automatic logic exp_acc(input logic [31:0] g, input rxf_frame_t f);
    logic k, p, r;
    k = g[12] ^ f.csumHit;
    case (g[11:8])
      4'h1: p = k;
      4'h2, 4'h3: p = k & f.stationHit;
      4'h4, 4'h5: p = k & f.unicast;
      4'h6, 4'h7: p = k & f.broadcast;
      4'h8: p = k & f.hashHit;
      4'h9: p = k & f.wakeHit;
      default: p = 1'b0;
    endcase
    r = f.length < RXF_MIN_LEN;
    p |= g[3] & f.stationHit | g[2] & f.unicast & ~f.stationHit | g[1] & f.multicast
      | g[0] & f.broadcast | g[15] & f.hashHit | g[14] & f.wakeHit;
    return p & ~(g[7] & f.fcsValid) & ~(g[6] & ~f.fcsValid)
      & ~(g[5] & ~(r & (f.fcsValid | ~g[6]))) & ~(g[4] & r);
  endfunction
  task automatic frame(input rxf_frame_t f);
    logic e;
    e = exp_acc(c, f);
    if (e) begin
      nAcc = nAcc + 16'h0001;
    end else begin
      nRej = nRej + 16'h0001;
    end
    mac.send(f);
    @(negedge sys_clk);
    cmp2("verdict", {e, ~e}, verdictValid_r ? verdict_r : '0);
  endtask
  ////////////////////////////////////////
  initial begin
    #9000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(5'h00, RXF_CFG_RESET);
    bus(1'b1, 5'h00, 32'hFFFFFFFF, junk);
    rd(5'h00, RXF_CFG_MASK);
    bus(1'b1, 5'h04, 32'h0000F0F0, junk);
    rd(5'h04, 32'h00000000);
    rd(5'h00, 32'h00000F0F);
    bus(1'b1, 5'h08, 32'h00002030, junk);
    rd(5'h08, 32'h00000000);
    rd(5'h00, 32'h00000F3F);
    bus(1'b1, 5'h0C, 32'h0000FFFF, junk);
    rd(5'h0C, 32'h00000000);
    rd(5'h00, 32'h0000D0C0);
    bus(1'b1, 5'h14, 32'hFFFFFFFF, junk);
    rd(5'h14, RXF_UNMAPPED);
    rd(5'h00, 32'h0000D0C0);
    // Pattern modes, then qualifiers with all passes on, then each bit alone
    for (int k = 0; k < 64; k++) begin
      c = (k < 32) ? {19'h00000, k[0], k[4:1], 8'h00}
        : (k < 48) ? 32'h0000C00F | 32'((k - 32) << 4) : 32'h00000001 << (k - 48);
      bus(1'b1, 5'h00, c, junk);
      for (int j = 0; j < 512; j++) begin
        fi = {j[0] & j[1], j[1], j[2], j[3], j[4], j[5], j[6], j[7],
          j[8] ? 16'h0040 : 16'h003F};
        frame(fi);
      end
    end
    rd(5'h10, {nRej, nAcc});
    give_verdict();
  end
endmodule // rxf_filter_bench
bind rxf_filter rxf_filter_sva chk (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
  .frameValid(frameValid), .frameInfo(frameInfo), .verdict_r(verdict_r),
  .verdictValid_r(verdictValid_r), .cfgOut_r(cfgOut_r));
`default_nettype wire
